// file: core/slcfg_defs.svh
// Register indices, field positions, reset values, header codes and the sync threshold width for the link framing configuration block
`ifndef SLCFG_DEFS_SVH
`define SLCFG_DEFS_SVH

`define SLCFG_IDX_CHANNEL_PAIR_ENABLE 12'h209
`define SLCFG_IDX_SH_SEL 12'h20F
`define SLCFG_IDX_SYNC_TH 12'h210
`define SLCFG_IDX_LINK_CTRL 12'h300
`define SLCFG_IDX_STATUS 12'h301
`define SLCFG_RST_CHANNEL_PAIR_ENABLE 8'h03
`define SLCFG_RST_SH_SEL 8'h00
`define SLCFG_RST_SYNC_TH 8'h03
`define SLCFG_RST_LINK_CTRL 8'h00
`define SLCFG_BIT_FIRST_PAIR 0
`define SLCFG_BIT_SECOND_PAIR 1
`define SLCFG_BIT_SOLO 2
`define SLCFG_BIT_LINK_EN 0
`define SLCFG_BIT_CAL_EN 1
`define SLCFG_SH_CRC12 2'h0
`define SLCFG_SH_FEC 2'h2
`define SLCFG_SYNC_TH_W 5

`endif

// file: core/slcfg_pkg.sv
// Types shared by the link framing configuration block
package slcfg_pkg;

  typedef enum logic [1:0] {SLCFG_HDR_CRC12, SLCFG_HDR_RSVD1, SLCFG_HDR_FEC, SLCFG_HDR_RSVD3} slcfg_hdr_t;

  // Frame layout handed to the lane mapper, frozen while the link runs
  typedef struct packed {
    logic [3:0] chan_on;
    logic solo;
    logic [4:0] lanes;
    logic [4:0] convs;
    logic tail_pad;
    logic swap_cd_to_ab;
    logic [1:0] hdr_mode;
    logic hdr_active;
    logic [2:0] hdr_cmd;
  } slcfg_layout_t;

  // Static link parameters from the link mode decoder
  typedef struct packed {
    logic [4:0] lanes_cfg;
    logic [4:0] convs_cfg;
    logic enc_64b66b;
  } slcfg_mode_t;

endpackage : slcfg_pkg

// file: core/slcfg_sync_det.sv
// Filter that turns long enough low runs on the sync request pin into requests
`timescale 1ns/1ps
`default_nettype none
`include "slcfg_defs.svh"
module slcfg_sync_det
  import slcfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic arm,
  input wire logic sync_n_pin,
  input wire logic [`SLCFG_SYNC_TH_W-1:0] thresh,
  output logic sync_req,
  output logic sync_level_n
);

  logic meta_ff;
  logic sync_ff;
  logic [5:0] low_cnt_ff;

  // Two flops before anything reads the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else if (ce)
    begin
      meta_ff <= sync_n_pin;
      sync_ff <= meta_ff;
    end
  end

  // Count consecutive low samples, saturating so a held request stays one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_cnt_ff <= 6'h00;
    else if (ce)
    begin
      if (sync_ff || !arm)
        low_cnt_ff <= 6'h00;
      else if (low_cnt_ff != 6'h3F)
        low_cnt_ff <= low_cnt_ff + 6'h01;
    end
  end

  // Short lows are error reports and never raise a request
  // The count lags the current low sample by one, so count >= threshold means threshold plus one lows
  assign sync_req = arm && !sync_ff && (low_cnt_ff >= {1'b0, thresh});
  assign sync_level_n = sync_ff;

endmodule : slcfg_sync_det
`default_nettype wire

// file: core/slcfg_top.sv
// APB register block and frame layout control for the serial link
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slcfg_defs.svh"
module slcfg_top
  import slcfg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire slcfg_pkg::slcfg_mode_t LINK_MODE,
  input wire logic SYNC_N,
  output var slcfg_pkg::slcfg_layout_t LAYOUT,
  output logic LINK_RUN,
  output logic CAL_RUN,
  output logic SYNC_REQ
);
  import slcfg_pkg::*;

  logic [7:0] channel_pair_enable_ff;
  logic [7:0] sh_sel_ff;
  logic [7:0] sync_th_ff;
  logic [7:0] link_ctrl_ff;
  logic link_en_d_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  slcfg_layout_t layout_ff;
  slcfg_layout_t nxt_layout;
  logic sync_req_w;
  logic sync_level_n_w;

  // Byte address is four times the printed register index
  function automatic logic hit(input logic [13:0] addr, input logic [11:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction : hit

  // Ceiling of half, reused for lanes
  function automatic logic [4:0] half_up(input logic [4:0] n);
    // One extra bit so a count of 31 does not wrap to zero before halving
    half_up = 5'(({1'b0, n} + 6'h01) >> 1);
  endfunction : half_up

  wire access = PSEL && PENABLE && CLK_EN;
  wire wr = access && PWRITE && PSTRB[0];
  wire mapped = hit(PADDR, `SLCFG_IDX_CHANNEL_PAIR_ENABLE) || hit(PADDR, `SLCFG_IDX_SH_SEL)
    || hit(PADDR, `SLCFG_IDX_SYNC_TH) || hit(PADDR, `SLCFG_IDX_LINK_CTRL)
    || hit(PADDR, `SLCFG_IDX_STATUS);
  wire link_en = link_ctrl_ff[`SLCFG_BIT_LINK_EN];

  // Zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PRDATA = rdata_ff;
  assign PSLVERR = slverr_ff;

  // Register writes; reserved bits are stored as written, software keeps them zero
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      channel_pair_enable_ff <= `SLCFG_RST_CHANNEL_PAIR_ENABLE;
      sh_sel_ff <= `SLCFG_RST_SH_SEL;
      sync_th_ff <= `SLCFG_RST_SYNC_TH;
      link_ctrl_ff <= `SLCFG_RST_LINK_CTRL;
    end
    else if (wr)
    begin
      if (hit(PADDR, `SLCFG_IDX_CHANNEL_PAIR_ENABLE))
        channel_pair_enable_ff <= PWDATA[7:0];
      if (hit(PADDR, `SLCFG_IDX_SH_SEL))
        sh_sel_ff <= PWDATA[7:0];
      if (hit(PADDR, `SLCFG_IDX_SYNC_TH))
        sync_th_ff <= PWDATA[7:0];
      if (hit(PADDR, `SLCFG_IDX_LINK_CTRL))
        link_ctrl_ff <= PWDATA[7:0];
    end
  end

  // Read data registered at the end of the setup phase; unmapped reads give zero and an error
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end
    else if (CLK_EN)
    begin
      slverr_ff <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE)
      begin
        if (hit(PADDR, `SLCFG_IDX_CHANNEL_PAIR_ENABLE))
          rdata_ff <= {24'h000000, channel_pair_enable_ff};
        else if (hit(PADDR, `SLCFG_IDX_SH_SEL))
          rdata_ff <= {24'h000000, sh_sel_ff};
        else if (hit(PADDR, `SLCFG_IDX_SYNC_TH))
          rdata_ff <= {24'h000000, sync_th_ff};
        else if (hit(PADDR, `SLCFG_IDX_LINK_CTRL))
          rdata_ff <= {24'h000000, link_ctrl_ff};
        else if (hit(PADDR, `SLCFG_IDX_STATUS))
          rdata_ff <= {17'h00000, layout_ff.lanes, layout_ff.convs, sync_level_n_w, layout_ff.chan_on};
        else
          rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Layout computed from the software settings
  always_comb
  begin
    logic first_on;
    logic second_on;
    logic solo;
    logic reduced;
    first_on = channel_pair_enable_ff[`SLCFG_BIT_FIRST_PAIR];
    second_on = channel_pair_enable_ff[`SLCFG_BIT_SECOND_PAIR];
    solo = channel_pair_enable_ff[`SLCFG_BIT_SOLO];
    reduced = solo || !first_on || !second_on;
    nxt_layout = '0;
    nxt_layout.solo = solo;
    // Solo mode keeps only channel A; relies on software holding first pair on
    if (solo)
      nxt_layout.chan_on = 4'h1;
    else
      nxt_layout.chan_on = {second_on, second_on, first_on, first_on};
    // Half the lanes and converters when a pair is off or solo mode is set
    if (reduced)
    begin
      nxt_layout.lanes = half_up(LINK_MODE.lanes_cfg);
      nxt_layout.convs = LINK_MODE.convs_cfg >> 1;
      nxt_layout.tail_pad = LINK_MODE.lanes_cfg[0];
    end
    else
    begin
      nxt_layout.lanes = LINK_MODE.lanes_cfg;
      nxt_layout.convs = LINK_MODE.convs_cfg;
    end
    // C and D move into the A and B slots
    nxt_layout.swap_cd_to_ab = !solo && !first_on && second_on;
    // Header mode only matters for 64B/66B
    nxt_layout.hdr_active = LINK_MODE.enc_64b66b;
    nxt_layout.hdr_mode = LINK_MODE.enc_64b66b ? sh_sel_ff[1:0] : `SLCFG_SH_CRC12;
    nxt_layout.hdr_cmd = 3'h0;
  end

  // Snapshot on the rising link enable so the frame stays fixed while running
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      link_en_d_ff <= 1'b0;
      layout_ff <= '0;
    end
    else if (CLK_EN)
    begin
      link_en_d_ff <= link_en;
      if (link_en && !link_en_d_ff)
        layout_ff <= nxt_layout;
    end
  end

  assign LAYOUT = layout_ff;
  assign LINK_RUN = link_en_d_ff;
  assign CAL_RUN = link_ctrl_ff[`SLCFG_BIT_CAL_EN];
  assign SYNC_REQ = sync_req_w;

  // Sync pin filter, armed only while the link runs
  slcfg_sync_det u_sync
  (
    .clk(SYS_CLK),
    .rst(RESET),
    .ce(CLK_EN),
    .arm(link_en_d_ff),
    .sync_n_pin(SYNC_N),
    .thresh(sync_th_ff[`SLCFG_SYNC_TH_W-1:0]),
    .sync_req(sync_req_w),
    .sync_level_n(sync_level_n_w)
  );

endmodule : slcfg_top
`default_nettype wire

// file: test/slcfg_top_sva.sv
// Port assertions for the link framing configuration block
`timescale 1ns/1ps
`default_nettype none
module slcfg_top_sva
  import slcfg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire slcfg_pkg::slcfg_mode_t LINK_MODE,
  input wire logic SYNC_N,
  input wire slcfg_pkg::slcfg_layout_t LAYOUT,
  input wire logic LINK_RUN,
  input wire logic SYNC_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Any channel off means a reduced layout
  logic red;
  assign red = LAYOUT.chan_on != 4'hF;
  solo_map_a: assert property (LAYOUT.solo |-> LAYOUT.chan_on == 4'h1) else $error("solo map");
  swap_map_a: assert property (LAYOUT.swap_cd_to_ab |-> LAYOUT.chan_on == 4'hC) else $error("swap map");
  lane_scale_a:
    assert property ($rose(LINK_RUN) && red |-> LAYOUT.convs == $past(LINK_MODE.convs_cfg) >> 1
      && LAYOUT.lanes == 5'((6'($past(LINK_MODE.lanes_cfg)) + 6'h1) >> 1)) else $error("scale");
  tail_pad_a:
    assert property ($rose(LINK_RUN) |-> LAYOUT.tail_pad == (red && $past(LINK_MODE.lanes_cfg[0])))
      else $error("tail pad");
  idle_cmd_a: assert property (LINK_RUN |-> LAYOUT.hdr_cmd == 3'h0) else $error("cmd");
  hdr_gate_a:
    assert property ($rose(LINK_RUN) |-> LAYOUT.hdr_active == $past(LINK_MODE.enc_64b66b)
      && (LAYOUT.hdr_active || LAYOUT.hdr_mode == 2'h0)) else $error("hdr gate");
  layout_hold_a: assert property (LINK_RUN && $past(LINK_RUN) |-> $stable(LAYOUT)) else $error("hold");
  sync_gate_a: assert property (SYNC_REQ |-> LINK_RUN) else $error("sync gate");
  // Assumes the default threshold of three
  sync_len_a: assert property ($rose(SYNC_REQ) |-> !$past(SYNC_N, 2) && !$past(SYNC_N, 4)) else $error("sync");
endmodule : slcfg_top_sva
bind slcfg_top slcfg_top_sva chk (.SYS_CLK, .RESET, .LINK_MODE, .SYNC_N, .LAYOUT, .LINK_RUN, .SYNC_REQ);
`default_nettype wire

// file: test/slcfg_rx_model.sv
// Far-side receiver model that pulls the sync request line low
`timescale 1ns/1ps
`default_nettype none
module slcfg_rx_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [4:0] len,
  output logic sync_n
);
  logic [4:0] cnt_ff;
  // Low for len cycles; short runs act as error reports
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_ff <= 5'h00;
    else if (go)
      cnt_ff <= len;
    else if (cnt_ff != 5'h00)
      cnt_ff <= cnt_ff - 5'h01;
  assign sync_n = cnt_ff == 5'h00; // Idle high between requests
endmodule : slcfg_rx_model
`default_nettype wire

// file: test/test_serial_link_channel_framing_cfg.sv
// Self-checking bench for the link framing configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED t=%0t %0h/%0h", $time, g, e); end end
module test_serial_link_channel_framing_cfg;
  import slcfg_pkg::*;
  logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, go = 0, pready, pslverr, run, cal, sreq, sync_n, red;
  logic [13:0] paddr = 14'h0000, ad;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [4:0] len = 5'h00;
  logic [7:0] dd, ch;
  logic [7:0] cfg [4] = '{8'h03, 8'h01, 8'h02, 8'h05};
  logic [1:0] sh;
  slcfg_mode_t mode = '0;
  slcfg_layout_t lay, el;
  int err_total = 0, compares = 0, seen;
  int regs [int];
  initial forever #20 clk = ~clk;
  slcfg_top uut (.SYS_CLK(clk), .RESET(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .LINK_MODE(mode),
    .SYNC_N(sync_n), .LAYOUT(lay), .LINK_RUN(run), .CAL_RUN(cal), .SYNC_REQ(sreq));
  slcfg_rx_model rx (.clk(clk), .rst(rst), .go(go), .len(len), .sync_n(sync_n));
  // One APB transfer; waits on pready, takes data at that edge
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    `CHK(pslverr, !regs.exists(a) && a != 14'hC04)
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
    if (regs.exists(a))
      regs[a] = d;
  endtask : wr
  task automatic rd(input logic [13:0] a);
    xfer(1'b0, a, 32'h0);
    `CHK(rdata, regs.exists(a) ? regs[a] : 0)
  endtask : rd
  task automatic results;
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // Main sequence
  initial
  begin
    void'($urandom(32'hDCFD));
    regs = '{14'h824: 3, 14'h83C: 0, 14'h840: 3, 14'hC00: 0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[k]) rd(14'(k));
    rd(14'h0004);
    for (int i = 0; i < 6; i++)
    begin
      ad = i[0] ? 14'h840 : 14'h83C;
      dd = 8'($urandom) & (i[0] ? 8'h1F : 8'h03);
      wr(ad, dd);
      rd(ad);
    end
    wr(14'h840, 8'h03);
    pstrb <= 4'hE;
    xfer(1'b1, 14'h840, 32'h1F);
    pstrb <= 4'hF;
    rd(14'h840);
    // Clock enable low freezes the registers, so this write is lost
    ce <= 1'b0;
    xfer(1'b1, 14'h840, 32'h07);
    ce <= 1'b1;
    rd(14'h840);
    // Every header code, with solo mode keeping the first pair on
    for (int i = 0; i < 4; i++)
    begin
      ch = cfg[i];
      sh = 2'(i);
      wr(14'hC00, 8'h00);
      wr(14'h824, ch);
      `CHK(cal, 1'b0)
      `CHK(run, 1'b0)
      wr(14'h83C, {6'h00, sh});
      mode <= 11'($urandom) | 11'(~i & 1);
      wr(14'hC00, {6'h00, 1'(i & 1), 1'b1});
      repeat (2) @(posedge clk);
      `CHK(run, 1'b1)
      `CHK(cal, 1'(i & 1))
      el = '0;
      el.solo = ch[2];
      el.chan_on = ch[2] ? 4'h1 : {ch[1], ch[1], ch[0], ch[0]};
      red = el.chan_on != 4'hF;
      el.lanes = red ? 5'((6'(mode.lanes_cfg) + 6'h1) >> 1) : mode.lanes_cfg;
      el.convs = red ? mode.convs_cfg >> 1 : mode.convs_cfg;
      el.tail_pad = red & mode.lanes_cfg[0];
      el.swap_cd_to_ab = ch[1] & !ch[0] & !ch[2];
      el.hdr_active = mode.enc_64b66b;
      el.hdr_mode = mode.enc_64b66b ? sh : 2'h0;
      `CHK(lay, el)
      mode <= ~mode;
      repeat (3) @(posedge clk);
      `CHK(lay, el)
      // Status word mirrors the latched layout; sync line idles high
      xfer(1'b0, 14'hC04, 32'h0);
      `CHK(rdata, {17'h00000, el.lanes, el.convs, 1'b1, el.chan_on})
    end
    // Three low samples are an error report, four a request
    for (int n = 3; n < 5; n++)
    begin
      seen = 0;
      len <= 5'(n);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (12) @(posedge clk) seen |= sreq;
      `CHK(seen, int'(n == 4))
    end
    results();
  end
  // Watchdog well past the expected run length
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
endmodule : test_serial_link_channel_framing_cfg
`default_nettype wire
